// *** design/trig_delay_pkg.sv ***
// package: register map, field layout, reset values and carriers for trigger routing
`default_nettype none
package trig_delay_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_DLY_A = 8'h08;
  localparam logic [7:0] OFF_DLY_B = 8'h0c;
  localparam logic [7:0] OFF_SCR = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] UNIT_STRIDE = 8'h20;
  localparam logic [7:0] OFF_AMP_MAIN = 8'h40;
  localparam logic [7:0] OFF_AMP_AUX = 8'h44;
  localparam logic [7:0] OFF_WIN_MODE = 8'h48;
  localparam logic [7:0] OFF_ADC_SEL = 8'h4c;

  // ----------------------------------------
  // decoded register codes
  // ----------------------------------------
  localparam logic [2:0] F_CTRL1 = 3'h0;
  localparam logic [2:0] F_CTRL2 = 3'h1;
  localparam logic [2:0] F_DLY_A = 3'h2;
  localparam logic [2:0] F_DLY_B = 3'h3;
  localparam logic [2:0] F_SCR = 3'h4;
  localparam logic [2:0] F_STAT = 3'h5;
  localparam logic [4:0] REG_AMP_MAIN = 5'h10;
  localparam logic [4:0] REG_AMP_AUX = 5'h11;
  localparam logic [4:0] REG_WIN_MODE = 5'h12;
  localparam logic [4:0] REG_ADC_SEL = 5'h13;
  localparam logic [4:0] REG_NONE = 5'h1f;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LOAD_BIT = 0;
  localparam int A_EN_HI = 2;
  localparam int A_EN_LO = 1;
  localparam int B_EN_HI = 5;
  localparam int B_EN_LO = 4;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 2;
  localparam int SCR_EN_BIT = 7;
  localparam int SCR_PIN_BIT = 6;
  localparam int AMP_TM_BIT = 7;
  localparam int AMP_GAIN_HI = 6;
  localparam int AMP_GAIN_LO = 2;
  localparam int AMP_EN_BIT = 0;
  localparam int CAL_HI = 4;
  localparam int CAL_LO = 3;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [2:0] SRC_COMP1 = 3'h1;
  localparam logic [2:0] SRC_COMP2 = 3'h2;
  localparam logic [2:0] SRC_COMP3 = 3'h3;
  localparam logic [2:0] SRC_INIT = 3'h4;
  localparam logic TM_HW = 1'b0;
  localparam logic [1:0] CAL_MISSION = 2'h0;
  localparam logic [4:0] AMP_ADC_CHANNEL = 5'h0d;
  localparam logic [15:0] CNT_START = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam logic [7:0] AMP_RST = 8'h00;
  localparam logic [2:0] WIN_RST = 3'h0;
  localparam logic [4:0] ADC_SEL_RST = 5'h00;

  // ----------------------------------------
  // carriers and state
  // ----------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] dly_a;
    logic [15:0] dly_b;
    logic [7:0] scr;
    logic [15:0] act_a;
    logic [15:0] act_b;
    logic [15:0] cnt;
    logic run;
    logic prev;
    logic trig_a;
    logic trig_b;
    logic pulse;
  } unit_t;

  typedef struct packed {
    unit_t [1:0] u;
    logic [7:0] amp_main;
    logic [7:0] amp_aux;
    logic [2:0] win_mode;
    logic [4:0] adc_sel;
    logic [2:0] cmp_s1;
    logic [2:0] cmp_s2;
    logic amp_trig;
    logic adc_trig;
    logic [4:0] adc_chan;
    logic [31:0] prdata;
  } state_t;

  localparam unit_t UNIT_RST = '{ctrl1: CTRL_RST, ctrl2: CTRL_RST, dly_a: DLY_RST,
    dly_b: DLY_RST, scr: CTRL_RST, act_a: DLY_RST, act_b: DLY_RST, cnt: DLY_RST,
    run: 1'b0, prev: 1'b0, trig_a: 1'b0, trig_b: 1'b0, pulse: 1'b0};

  localparam state_t STATE_RST = '{u: {UNIT_RST, UNIT_RST}, amp_main: AMP_RST,
    amp_aux: AMP_RST, win_mode: WIN_RST, adc_sel: ADC_SEL_RST, cmp_s1: 3'h0,
    cmp_s2: 3'h0, amp_trig: 1'b0, adc_trig: 1'b0, adc_chan: ADC_SEL_RST,
    prdata: 32'h0000_0000};

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  function automatic logic [4:0] reg_decode(input logic [7:0] a);
    logic [4:0] r;
    r = REG_NONE;
    if (a[1:0] == 2'h0 && a[7:6] == 2'h0)
    begin
      unique case (a[4:0])
        OFF_CTRL1[4:0]: r = {1'b0, a[5], F_CTRL1};
        OFF_CTRL2[4:0]: r = {1'b0, a[5], F_CTRL2};
        OFF_DLY_A[4:0]: r = {1'b0, a[5], F_DLY_A};
        OFF_DLY_B[4:0]: r = {1'b0, a[5], F_DLY_B};
        OFF_SCR[4:0]: r = {1'b0, a[5], F_SCR};
        OFF_STAT[4:0]: r = {1'b0, a[5], F_STAT};
        default: r = REG_NONE;
      endcase
    end
    else if (a == OFF_AMP_MAIN) r = REG_AMP_MAIN;
    else if (a == OFF_AMP_AUX) r = REG_AMP_AUX;
    else if (a == OFF_WIN_MODE) r = REG_WIN_MODE;
    else if (a == OFF_ADC_SEL) r = REG_ADC_SEL;
    return r;
  endfunction

  function automatic logic pick_source(input logic [3:0] src, input logic [2:0] sel);
    logic r;
    r = 1'b0;
    unique case (sel)
      SRC_COMP1: r = src[0];
      SRC_COMP2: r = src[1];
      SRC_COMP3: r = src[2];
      SRC_INIT: r = src[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

endpackage
`default_nettype wire

// *** design/trigger_delay_routing.sv ***
// trigger routing and two programmable delay units with apb register access
// ----------------------------------------
// Functional notes
// - both unit one triggers, unequal delays, amplifier off: two adc triggers
// - amplifier started only by unit one trigger a
// - amplifier conversions use adc channel 13
// - amplifier done raises adc trigger automatically
// - unit two pulse is comparator window
// - comparators 1..3 feed start inputs 1..3
// - enabled timer init trigger feeds input four
// - control first 0x36 enables triggers a and b
// - control first 0x06 enables trigger a only
// - control second 0x10 selects timer init trigger
// - control second 0x04 selects comparator one
// - load bit copies delays into active compares
// - status control 0xc0 enables unit and pin
// - delay b 300 fires 301 clocks after start edge
// - comparator rising edge starts delayed trigger
// - windowed comparator edges pass only inside window
// - amplifier hardware mode bit7 low, enable bit0
// - amplifier gain from bits 4..2, 1..32 for codes 0..5
// - calibration field 00 means mission mode
// - pulse rises at match a, falls at b
// - delays count bus clocks
// ----------------------------------------
//
// Design decisions made here: the placing of the registers and register access over APB.
`default_nettype none
module trigger_delay_routing
  import trig_delay_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire apb_req_t apb_in,
  output apb_rsp_t apb_out,
  input wire logic [2:0] comparator_output_in,
  input wire logic timer_init_trigger_in,
  input wire logic init_trigger_enable_in,
  input wire logic amp_sample_done_in,
  output logic [1:0] delayed_trigger_a_out,
  output logic [1:0] delayed_trigger_b_out,
  output logic [1:0] window_pulse_output_out,
  output logic [1:0] pulse_output_pin_out,
  output logic [2:0] comparator_window_out,
  output logic amp_hw_trigger_out,
  output logic amp_enable_out,
  output logic amp_mission_mode_out,
  output logic [5:0] amp_gain_out,
  output logic adc_trigger_out,
  output logic [4:0] adc_channel_out
);

  // ----------------------------------------
  // state and shared terms
  // ----------------------------------------
  state_t s_q;
  state_t s_d;
  logic [2:0] comp_gated;
  logic [3:0] start_src;
  logic amp_active;
  logic [4:0] bus_idx;
  logic bus_setup;
  logic bus_access;

  // comparator edges gated by unit two window
  assign comp_gated = s_q.cmp_s2 & (~s_q.win_mode | {3{s_q.u[1].pulse}});
  // start inputs one to three from comparators, four from timer
  assign start_src = {timer_init_trigger_in & init_trigger_enable_in, comp_gated};

  // hardware trigger mode, enabled, mission mode
  assign amp_active = s_q.amp_main[AMP_EN_BIT] && (s_q.amp_main[AMP_TM_BIT] == TM_HW) &&
    (s_q.amp_aux[CAL_HI:CAL_LO] == CAL_MISSION);

  assign bus_idx = reg_decode(apb_in.paddr);
  assign bus_setup = apb_in.psel && !apb_in.penable;
  assign bus_access = apb_in.psel && apb_in.penable;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic lvl;
    logic start;
    logic en;
    logic amatch;
    logic bmatch;
    logic a_to_adc;
    lvl = 1'b0;
    start = 1'b0;
    en = 1'b0;
    amatch = 1'b0;
    bmatch = 1'b0;
    a_to_adc = 1'b0;
    s_d = s_q;

    // two-flop synchroniser for comparator outputs
    s_d.cmp_s1 = comparator_output_in;
    s_d.cmp_s2 = s_q.cmp_s1;

    for (int i = 0; i < 2; i++)
    begin
      en = s_q.u[i].scr[SCR_EN_BIT];
      lvl = pick_source(start_src, s_q.u[i].ctrl2[SEL_HI:SEL_LO]);
      start = en && lvl && !s_q.u[i].prev;
      s_d.u[i].prev = lvl;
      amatch = s_q.u[i].run && (s_q.u[i].cnt == s_q.u[i].act_a);
      bmatch = s_q.u[i].run && (s_q.u[i].cnt == s_q.u[i].act_b);
      s_d.u[i].trig_a = amatch && (s_q.u[i].ctrl1[A_EN_HI:A_EN_LO] != 2'h0);
      s_d.u[i].trig_b = bmatch && (s_q.u[i].ctrl1[B_EN_HI:B_EN_LO] != 2'h0);
      if (amatch)
      begin
        s_d.u[i].pulse = 1'b1;
      end
      if (bmatch)
      begin
        s_d.u[i].pulse = 1'b0;
      end
      if (s_q.u[i].run)
      begin
        s_d.u[i].cnt = 16'(s_q.u[i].cnt + CNT_START);
        if (s_q.u[i].cnt == CNT_MAX)
        begin
          s_d.u[i].run = 1'b0;
        end
      end
      if (start)
      begin
        s_d.u[i].cnt = CNT_START;
        s_d.u[i].run = 1'b1;
      end
      if (!en)
      begin
        s_d.u[i].run = 1'b0;
        s_d.u[i].pulse = 1'b0;
        s_d.u[i].trig_a = 1'b0;
        s_d.u[i].trig_b = 1'b0;
      end
      // load bit moves buffered delays into compares, then clears
      if (s_q.u[i].ctrl1[LOAD_BIT])
      begin
        s_d.u[i].act_a = s_q.u[i].dly_a;
        s_d.u[i].act_b = s_q.u[i].dly_b;
        s_d.u[i].ctrl1[LOAD_BIT] = 1'b0;
      end
    end

    // amplifier and adc trigger routing, unit one only
    s_d.amp_trig = s_q.u[0].trig_a && amp_active;
    a_to_adc = s_q.u[0].trig_a && !amp_active;
    s_d.adc_trig = a_to_adc || s_q.u[0].trig_b || amp_sample_done_in;
    if (amp_sample_done_in)
    begin
      s_d.adc_chan = AMP_ADC_CHANNEL;
    end
    else if (a_to_adc || s_q.u[0].trig_b)
    begin
      s_d.adc_chan = s_q.adc_sel;
    end

    // apb read data captured in setup phase
    if (bus_setup)
    begin
      s_d.prdata = 32'h0000_0000;
      if (bus_idx[4] == 1'b0)
      begin
        unique case (bus_idx[2:0])
          F_CTRL1: s_d.prdata = {24'h0, s_q.u[bus_idx[3]].ctrl1};
          F_CTRL2: s_d.prdata = {24'h0, s_q.u[bus_idx[3]].ctrl2};
          F_DLY_A: s_d.prdata = {16'h0, s_q.u[bus_idx[3]].dly_a};
          F_DLY_B: s_d.prdata = {16'h0, s_q.u[bus_idx[3]].dly_b};
          F_SCR: s_d.prdata = {24'h0, s_q.u[bus_idx[3]].scr};
          F_STAT: s_d.prdata = {14'h0, s_q.u[bus_idx[3]].pulse, s_q.u[bus_idx[3]].run,
            s_q.u[bus_idx[3]].cnt};
          default: s_d.prdata = 32'h0000_0000;
        endcase
      end
      else
      begin
        unique case (bus_idx)
          REG_AMP_MAIN: s_d.prdata = {24'h0, s_q.amp_main};
          REG_AMP_AUX: s_d.prdata = {24'h0, s_q.amp_aux};
          REG_WIN_MODE: s_d.prdata = {29'h0, s_q.win_mode};
          REG_ADC_SEL: s_d.prdata = {27'h0, s_q.adc_sel};
          default: s_d.prdata = 32'h0000_0000;
        endcase
      end
    end

    // apb write in access phase
    if (bus_access && apb_in.pwrite)
    begin
      if (bus_idx[4] == 1'b0)
      begin
        unique case (bus_idx[2:0])
          F_CTRL1: s_d.u[bus_idx[3]].ctrl1 = apb_in.pwdata[7:0];
          F_CTRL2: s_d.u[bus_idx[3]].ctrl2 = apb_in.pwdata[7:0];
          F_DLY_A: s_d.u[bus_idx[3]].dly_a = apb_in.pwdata[15:0];
          F_DLY_B: s_d.u[bus_idx[3]].dly_b = apb_in.pwdata[15:0];
          F_SCR: s_d.u[bus_idx[3]].scr = apb_in.pwdata[7:0];
          default: s_d.prdata = s_d.prdata;
        endcase
      end
      else
      begin
        unique case (bus_idx)
          REG_AMP_MAIN: s_d.amp_main = apb_in.pwdata[7:0];
          REG_AMP_AUX: s_d.amp_aux = apb_in.pwdata[7:0];
          REG_WIN_MODE: s_d.win_mode = apb_in.pwdata[2:0];
          REG_ADC_SEL: s_d.adc_sel = apb_in.pwdata[4:0];
          default: s_d.prdata = s_d.prdata;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in) s_q <= STATE_RST;
    else s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign apb_out.prdata = s_q.prdata;
  assign apb_out.pready = bus_access;
  assign apb_out.pslverr = bus_access && (bus_idx == REG_NONE);

  for (genvar g = 0; g < 2; g++)
  begin : g_unit_out
    assign delayed_trigger_a_out[g] = s_q.u[g].trig_a;
    assign delayed_trigger_b_out[g] = s_q.u[g].trig_b;
    assign window_pulse_output_out[g] = s_q.u[g].pulse;
    assign pulse_output_pin_out[g] = s_q.u[g].pulse && s_q.u[g].scr[SCR_PIN_BIT];
  end

  assign comparator_window_out = {3{s_q.u[1].pulse}};
  assign amp_hw_trigger_out = s_q.amp_trig;
  assign amp_enable_out = s_q.amp_main[AMP_EN_BIT];
  assign amp_mission_mode_out = (s_q.amp_aux[CAL_HI:CAL_LO] == CAL_MISSION);
  assign amp_gain_out = 6'(6'h01 << s_q.amp_main[AMP_GAIN_LO+2:AMP_GAIN_LO]);
  assign adc_trigger_out = s_q.adc_trig;
  assign adc_channel_out = s_q.adc_chan;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_load_write;
    bus_access && apb_in.pwrite && (bus_idx == {2'h0, F_CTRL1}) && apb_in.pwdata[LOAD_BIT];
  endsequence

  sequence s_comp_start;
    $rose(comp_gated[0]) && (s_q.u[0].ctrl2[SEL_HI:SEL_LO] == SRC_COMP1) &&
      s_q.u[0].scr[SCR_EN_BIT];
  endsequence

  property p_amp_only_a;
    amp_hw_trigger_out |-> $past(s_q.u[0].trig_a) && !$past(s_q.u[0].trig_b && !s_q.u[0].trig_a);
  endproperty
  a_amp_only_a: assert property (p_amp_only_a) else $error("amp trigger without trigger a");

  property p_two_triggers;
    (s_q.u[0].trig_b || (s_q.u[0].trig_a && !amp_active)) |=> adc_trigger_out;
  endproperty
  a_two_triggers: assert property (p_two_triggers) else $error("adc trigger missing");

  property p_amp_done;
    amp_sample_done_in |=> adc_trigger_out;
  endproperty
  a_amp_done: assert property (p_amp_done) else $error("amplifier done not forwarded");

  property p_amp_channel;
    amp_sample_done_in |=> (adc_channel_out == AMP_ADC_CHANNEL);
  endproperty
  a_amp_channel: assert property (p_amp_channel) else $error("wrong adc channel");

  property p_load;
    s_load_write |-> ##2 (s_q.u[0].act_a == s_q.u[0].dly_a) && !s_q.u[0].ctrl1[LOAD_BIT];
  endproperty
  a_load: assert property (p_load) else $error("delay values not loaded");

  property p_pulse_rise;
    $rose(s_q.u[1].pulse) |-> $past(s_q.u[1].run && (s_q.u[1].cnt == s_q.u[1].act_a));
  endproperty
  a_pulse_rise: assert property (p_pulse_rise) else $error("pulse rose off match a");

  property p_trig_single;
    s_q.u[0].trig_a |=> !s_q.u[0].trig_a;
  endproperty
  a_trig_single: assert property (p_trig_single) else $error("trigger a wider than one clock");

  property p_window_gate;
    (s_q.win_mode[0] && !s_q.u[1].pulse) |-> !comp_gated[0];
  endproperty
  a_window_gate: assert property (p_window_gate) else $error("edge passed outside window");

  property p_init_gate;
    !init_trigger_enable_in |-> !start_src[3];
  endproperty
  a_init_gate: assert property (p_init_gate) else $error("init trigger passed while off");

  property p_comp_start;
    s_comp_start |=> s_q.u[0].run && (s_q.u[0].cnt == CNT_START);
  endproperty
  a_comp_start: assert property (p_comp_start) else $error("comparator edge did not start");

endmodule
`default_nettype wire

// *** verif/trig_partner.sv ***
// partner model: timer init trigger source and amplifier sampling response
`default_nettype none
module trig_partner
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [7:0] latency_in,
  input wire logic amp_hw_trigger_in,
  output logic timer_init_trigger_out,
  output logic amp_sample_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] tcnt_q;
  logic [7:0] acnt_q;
  // ----------------------------------------
  // timer: one init trigger per 600-clock period
  // ----------------------------------------
  always @(posedge core_clk_in)
  begin
    if (rst_in || !run_in) tcnt_q <= 10'h000;
    else tcnt_q <= (tcnt_q == 10'h257) ? 10'h000 : tcnt_q + 10'h001;
    timer_init_trigger_out <= run_in && !rst_in && tcnt_q == 10'h000;
  end
  // ----------------------------------------
  // amplifier: done pulse latency after hw trigger
  // ----------------------------------------
  always @(posedge core_clk_in)
  begin
    if (rst_in) acnt_q <= 8'h00;
    else if (amp_hw_trigger_in) acnt_q <= latency_in;
    else if (acnt_q != 8'h00) acnt_q <= acnt_q - 8'h01;
    amp_sample_done_out <= !rst_in && acnt_q == 8'h01;
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// testbench: register table, routing and delay timing checks
`default_nettype none
module tb
  import trig_delay_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [2:0] comp = 3'h0;
  logic init_en = 1'b0;
  logic run = 1'b0;
  logic [7:0] lat = 8'h01;
  logic tinit, done, done_d, amp_hw, amp_en, amp_mis, adc_t;
  logic [1:0] trig_a, trig_b, pul, pin;
  logic [2:0] cwin;
  logic [5:0] gain;
  logic [4:0] ch, ampch;
  logic [31:0] rd_v;
  logic er_v;
  int errors = 0, checks_done = 0, cyc = 0, na = 0, nb = 0, nadc = 0, namp = 0, pw2 = 0;
  int pinerr = 0, winerr = 0, t_a = 0, t_b = 0, t_s = 0;
  int s_a, s_b, s_adc, s_amp, s_pw;
  row_t rows [0:13] = '{'{8'h00, 32'h36, 32'h36, 1'b0}, '{8'h04, 32'h10, 32'h10, 1'b0},
    '{8'h08, 32'h1_2345, 32'h2345, 1'b0}, '{8'h0c, 32'h12c, 32'h12c, 1'b0},
    '{8'h10, 32'hc0, 32'hc0, 1'b0}, '{8'h24, 32'h04, 32'h04, 1'b0},
    '{8'h28, 32'hfa, 32'hfa, 1'b0}, '{8'h2c, 32'h15e, 32'h15e, 1'b0},
    '{8'h40, 32'h85, 32'h85, 1'b0}, '{8'h44, 32'h1a, 32'h1a, 1'b0},
    '{8'h48, 32'h0f, 32'h07, 1'b0}, '{8'h4c, 32'h3f, 32'h1f, 1'b0},
    '{8'h18, 32'hff, 32'h00, 1'b1}, '{8'h41, 32'hff, 32'h00, 1'b1}};

  always #10 core_clk_in = ~core_clk_in;

  trigger_delay_routing dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .apb_in(req),
    .apb_out(rsp), .comparator_output_in(comp), .timer_init_trigger_in(tinit),
    .init_trigger_enable_in(init_en), .amp_sample_done_in(done),
    .delayed_trigger_a_out(trig_a), .delayed_trigger_b_out(trig_b),
    .window_pulse_output_out(pul), .pulse_output_pin_out(pin), .comparator_window_out(cwin),
    .amp_hw_trigger_out(amp_hw), .amp_enable_out(amp_en), .amp_mission_mode_out(amp_mis),
    .amp_gain_out(gain), .adc_trigger_out(adc_t), .adc_channel_out(ch));

  trig_partner partner (.core_clk_in(core_clk_in), .rst_in(rst_in), .run_in(run),
    .latency_in(lat), .amp_hw_trigger_in(amp_hw), .timer_init_trigger_out(tinit),
    .amp_sample_done_out(done));

  // ----------------------------------------
  // monitor of pulses and levels
  // ----------------------------------------
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    done_d <= done;
    if (tinit) t_s <= cyc;
    if (trig_a[0])
    begin
      na <= na + 1;
      t_a <= cyc;
    end
    if (trig_b[0])
    begin
      nb <= nb + 1;
      t_b <= cyc;
    end
    if (adc_t) nadc <= nadc + 1;
    if (amp_hw) namp <= namp + 1;
    if (pul[1]) pw2 <= pw2 + 1;
    if (pin !== pul) pinerr <= pinerr + 1;
    if (cwin !== {3{pul[1]}}) winerr <= winerr + 1;
    if (adc_t && done_d) ampch <= ch;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk_in);
    req.penable <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1)
    begin
      errors++;
      give_verdict();
    end
    rd_v = rsp.prdata;
    er_v = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic reset_dut;
    rst_in <= 1'b1;
    cycles(6);
    rst_in <= 1'b0;
  endtask

  task automatic snap;
    s_a = na;
    s_b = nb;
    s_adc = nadc;
    s_amp = namp;
    s_pw = pw2;
  endtask

  task automatic run_period(input int on, input int off);
    run <= 1'b1;
    cycles(on);
    run <= 1'b0;
    cycles(off);
  endtask

  task automatic comp_pulse(input logic [2:0] bits);
    comp <= bits;
    cycles(10);
    comp <= 3'h0;
    cycles(20);
  endtask

  initial
  begin
    repeat (100000) @(posedge core_clk_in);
    errors++;
    give_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    reset_dut();
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      check({31'h0, er_v}, {31'h0, rows[i].e});
      apb(1'b0, rows[i].a, 32'h0);
      check(rd_v, rows[i].q);
      check({31'h0, er_v}, {31'h0, rows[i].e});
    end
    reset_dut();
    apb(1'b0, 8'h00, 32'h0);
    check(rd_v, 32'h0);
    check({trig_a, trig_b, pul, amp_en, adc_t}, 32'h0);
    apb(1'b1, 8'h00, 32'h36);
    apb(1'b1, 8'h04, 32'h10);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h0c, 32'd300);
    apb(1'b1, 8'h10, 32'hc0);
    snap();
    run_period(700, 10);
    check(32'(na - s_a), 32'h0);
    init_en <= 1'b1;
    snap();
    run_period(700, 10);
    check(32'(na - s_a), 32'h0);
    apb(1'b1, 8'h00, 32'h37);
    snap();
    run_period(1100, 400);
    check(32'(na - s_a), 32'h2);
    check(32'(nb - s_b), 32'h2);
    check(32'(nadc - s_adc), 32'h4);
    check(32'(namp - s_amp), 32'h0);
    check(32'(t_a - t_s), 32'd2);
    check(32'(t_b - t_s), 32'd301);
    apb(1'b1, 8'h40, 32'h05);
    apb(1'b1, 8'h44, 32'h02);
    cycles(2);
    check({amp_en, amp_mis, gain}, {2'h3, 6'h02});
    for (int i = 0; i < 2; i++)
    begin
      lat <= (i == 0) ? 8'h01 : 8'h28;
      snap();
      run_period(500, 400);
      check(32'(namp - s_amp), 32'h1);
      check(32'(nadc - s_adc), 32'h2);
      check({27'h0, ampch}, 32'd13);
    end
    apb(1'b1, 8'h40, 32'h85);
    apb(1'b1, 8'h4c, 32'h0c);
    snap();
    run_period(500, 400);
    check(32'(namp - s_amp), 32'h0);
    check(32'(nadc - s_adc), 32'h2);
    check({27'h0, ch}, 32'd12);
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b1, 8'h40, 32'h01 | (k << 2));
      cycles(2);
      check({26'h0, gain}, 32'h1 << k);
    end
    apb(1'b1, 8'h44, 32'h08);
    apb(1'b1, 8'h40, 32'h00);
    cycles(2);
    check({31'h0, amp_mis}, 32'h0);
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b1, 8'h00, 32'h07);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h04, 32'(i + 1) << 2);
      snap();
      comp_pulse(~(3'h1 << i));
      comp_pulse(3'h1 << i);
      check(32'(na - s_a), 32'h1);
      check(32'(nb - s_b), 32'h0);
    end
    apb(1'b1, 8'h04, 32'h04);
    apb(1'b1, 8'h48, 32'h01);
    apb(1'b1, 8'h28, 32'd250);
    apb(1'b1, 8'h2c, 32'd350);
    apb(1'b1, 8'h20, 32'h01);
    apb(1'b1, 8'h24, 32'h10);
    apb(1'b1, 8'h30, 32'hc0);
    snap();
    run <= 1'b1;
    cycles(50);
    comp_pulse(3'h1);
    cycles(220);
    comp_pulse(3'h1);
    cycles(120);
    comp_pulse(3'h1);
    run <= 1'b0;
    cycles(300);
    check(32'(na - s_a), 32'h1);
    check(32'(pw2 - s_pw), 32'd100);
    check(32'(winerr), 32'h0);
    check(32'(pinerr), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
